/* File: sac_conv_ctrl.sv */
// top of the conversion control: start decode, bit timing, busy, interrupt, read port
//
// Overview of operation
// - output straight binary with 0 V negative supply, twos complement with -5 V.
// - start on falling strobe, or on chip-select and read both low.
// - reset leaves conversion alone, only forces interrupt inactive high.
// - uncleared interrupt does not disturb later conversions.
// - MSB decided 50 ns after second qualified falling clock edge after start.
// - later bits decided 50 ns after each edge; nine clock cycles total.
// - at end, approximation register goes to output latch, then clears.
// - hold on start, back to tracking when busy rises.
// - on-chip oscillator stops after conversion until next start.
// - result delivered as one parallel 8-bit word.
// - busy low for the whole conversion, high at its end.
// - interrupt low at completion, high on rising chip-select or read.
// - with strobe tied high, chip-select plus read starts, busy goes low and the conversion runs to its end.
`timescale 1ns/1ps
`include "sac_cfg.svh"
module sac_conv_ctrl (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic por_n,
    input wire logic convert_strobe_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic clk_ext,
    input wire logic use_int_osc,
    input wire logic vss_neg,
    input wire logic comp_in,
    output logic busy_n,
    output logic int_n,
    output logic hold,
    output logic osc_run,
    output logic osc_level,
    output logic [7:0] dac_trial,
    output logic [7:0] parallel_data_bus,
    output logic data_oe
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    sac_pkg::sac_state_t state;
    sac_pkg::sac_state_t next_state;
    logic [3:0] edge_cnt;
    logic [3:0] next_edge_cnt;
    logic [7:0] since_start;
    logic [7:0] next_since_start;
    logic [7:0] dly_cnt;
    logic [7:0] next_dly_cnt;
    logic next_busy_n;
    logic next_int_n;
    logic next_hold;
    logic next_osc_run;
    logic [7:0] next_bus;
    logic next_oe;
    logic prev_strobe_n;
    logic prev_cs_n;
    logic prev_rd_n;
    logic prev_sel;
    logic sel;
    logic strobe_fall;
    logic sel_fall;
    logic start_req;
    logic start_ok;
    logic cs_rise;
    logic rd_rise;
    logic conv_fall;
    logic sar_load;
    logic sar_decide;
    logic [2:0] bit_idx;
    logic conv_done;
    logic [7:0] result;
    logic [7:0] qual_dly;

    assign qual_dly = 8'(`SAC_DEC_DLY_CYC);

    // ------------------------------------------------------------
    // start and release decode
    // ------------------------------------------------------------
    assign sel = !cs_n && !rd_n;
    assign strobe_fall = prev_strobe_n && !convert_strobe_n;
    assign sel_fall = sel && !prev_sel;
    // strobe tied high leaves the read access as the only start
    assign start_req = strobe_fall || sel_fall;
    // a request during busy is dropped; host is expected not to send one
    assign start_ok = start_req && (state == sac_pkg::sac_idle);
    assign cs_rise = cs_n && !prev_cs_n;
    assign rd_rise = rd_n && !prev_rd_n;

    always_ff @(posedge clk_sys) begin
        if (!por_n) begin
            prev_strobe_n <= 1'b1;
            prev_cs_n <= 1'b1;
            prev_rd_n <= 1'b1;
            prev_sel <= 1'b0;
        end else begin
            prev_strobe_n <= convert_strobe_n;
            prev_cs_n <= cs_n;
            prev_rd_n <= rd_n;
            prev_sel <= sel;
        end
    end

    // ------------------------------------------------------------
    // conversion clock
    // ------------------------------------------------------------
    sac_clk_src u_clk_src (
        .clk_sys(clk_sys),
        .por_n(por_n),
        .run(osc_run),
        .use_int_osc(use_int_osc),
        .clk_ext(clk_ext),
        .conv_fall(conv_fall),
        .osc_level(osc_level)
    );

    // ------------------------------------------------------------
    // approximation register
    // ------------------------------------------------------------
    sac_sar u_sar (
        .clk_sys(clk_sys),
        .por_n(por_n),
        .load(sar_load),
        .decide(sar_decide),
        .bit_idx(bit_idx),
        .comp_in(comp_in),
        .trial(dac_trial),
        .result(result)
    );

    assign sar_load = start_ok;
    assign bit_idx = 3'(edge_cnt - `SAC_FIRST_DEC_EDGE);
    assign sar_decide = (state == sac_pkg::sac_dly) && (dly_cnt >= qual_dly - 8'h01);
    assign conv_done = sar_decide && (bit_idx == `SAC_LAST_BIT);

    // ------------------------------------------------------------
    // bit timing state machine
    // ------------------------------------------------------------
    // only por_n touches this group: rstn must not upset a running conversion
    always_comb begin
        next_state = state;
        next_edge_cnt = edge_cnt;
        next_since_start = since_start;
        next_dly_cnt = dly_cnt;
        case (state)
            sac_pkg::sac_idle: begin
                next_edge_cnt = 4'h0;
                next_dly_cnt = 8'h00;
                next_since_start = 8'h00;
                if (start_ok) begin
                    next_state = sac_pkg::sac_conv;
                end
            end
            sac_pkg::sac_conv: begin
                if (since_start < qual_dly) begin
                    next_since_start = since_start + 8'h01;
                end
                if (conv_fall) begin
                    // an edge too close to the start is not the first one
                    if (edge_cnt != 4'h0 || since_start >= qual_dly) begin
                        next_edge_cnt = edge_cnt + 4'h1;
                        if (edge_cnt + 4'h1 >= `SAC_FIRST_DEC_EDGE) begin
                            next_state = sac_pkg::sac_dly;
                            next_dly_cnt = 8'h00;
                        end
                    end
                end
            end
            sac_pkg::sac_dly: begin
                // decision lands one settle delay after the edge
                if (sar_decide) begin
                    next_dly_cnt = 8'h00;
                    if (conv_done) begin
                        next_state = sac_pkg::sac_idle;
                    end else begin
                        next_state = sac_pkg::sac_conv;
                    end
                end else begin
                    next_dly_cnt = dly_cnt + 8'h01;
                end
            end
            default: begin
                next_state = sac_pkg::sac_idle;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!por_n) begin
            state <= sac_pkg::sac_idle;
            edge_cnt <= 4'h0;
            since_start <= 8'h00;
            dly_cnt <= 8'h00;
        end else begin
            state <= next_state;
            edge_cnt <= next_edge_cnt;
            since_start <= next_since_start;
            dly_cnt <= next_dly_cnt;
        end
    end

    // ------------------------------------------------------------
    // busy, hold and oscillator run
    // ------------------------------------------------------------
    always_comb begin
        next_busy_n = busy_n;
        next_hold = hold;
        next_osc_run = osc_run;
        if (start_ok) begin
            next_busy_n = 1'b0;
            next_hold = 1'b1;
            next_osc_run = 1'b1;
        end else if (conv_done) begin
            next_busy_n = 1'b1;
            next_hold = 1'b0;
            next_osc_run = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!por_n) begin
            busy_n <= 1'b1;
            hold <= 1'b0;
            osc_run <= 1'b0;
        end else begin
            busy_n <= next_busy_n;
            hold <= next_hold;
            osc_run <= next_osc_run;
        end
    end

    // ------------------------------------------------------------
    // completion interrupt
    // ------------------------------------------------------------
    // completion wins over any release in the same cycle
    always_comb begin
        next_int_n = int_n;
        if (conv_done) begin
            next_int_n = 1'b0;
        end else if (!rstn) begin
            next_int_n = 1'b1;
        end else if (cs_rise || rd_rise) begin
            next_int_n = 1'b1;
        end
    end

    // interrupt state never feeds the conversion path
    always_ff @(posedge clk_sys) begin
        if (!por_n) begin
            int_n <= 1'b1;
        end else begin
            int_n <= next_int_n;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_comb begin
        next_oe = sel;
        next_bus = 8'h00;
        if (sel) begin
            // twos complement is offset binary with the top bit flipped
            next_bus = vss_neg ? (result ^ `SAC_MSB_FLIP) : result;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!por_n) begin
            parallel_data_bus <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            parallel_data_bus <= next_bus;
            data_oe <= next_oe;
        end
    end
endmodule

/* File: sac_cfg.svh */
// timing counts, widths and reset values for the conversion control
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

`define SAC_SYS_PERIOD_NS 4
`define SAC_DEC_DLY_NS 50
`define SAC_DEC_DLY_CYC ((`SAC_DEC_DLY_NS + `SAC_SYS_PERIOD_NS - 1) / `SAC_SYS_PERIOD_NS)
`define SAC_OSC_HALF_NS 125
`define SAC_OSC_HALF_CYC (`SAC_OSC_HALF_NS / `SAC_SYS_PERIOD_NS)
`define SAC_NUM_BITS 8
`define SAC_FIRST_DEC_EDGE 4'h2
`define SAC_LAST_BIT 3'h7
`define SAC_CODE_RST 8'h00
`define SAC_CODE_START 8'h80
`define SAC_MSB_FLIP 8'h80

`endif

/* File: sac_pkg.sv */
// types shared by the conversion control files
package sac_pkg;
    typedef enum logic [1:0] {
        sac_idle,
        sac_conv,
        sac_dly
    } sac_state_t;
endpackage

/* File: sac_clk_src.sv */
// conversion clock source: sampled external clock or gated on-chip oscillator
`timescale 1ns/1ps
`include "sac_cfg.svh"
module sac_clk_src (
    input wire logic clk_sys,
    input wire logic por_n,
    input wire logic run,
    input wire logic use_int_osc,
    input wire logic clk_ext,
    output logic conv_fall,
    output logic osc_level
);
    logic [7:0] osc_cnt;
    logic [7:0] next_osc_cnt;
    logic next_osc_level;
    logic prev_ext;
    logic next_prev_ext;
    logic next_conv_fall;

    always_comb begin
        next_osc_cnt = osc_cnt;
        next_osc_level = osc_level;
        next_prev_ext = clk_ext;
        next_conv_fall = 1'b0;
        if (run && use_int_osc) begin
            if (osc_cnt >= 8'(`SAC_OSC_HALF_CYC - 1)) begin
                next_osc_cnt = 8'h00;
                next_osc_level = ~osc_level;
                next_conv_fall = osc_level;
            end else begin
                next_osc_cnt = osc_cnt + 8'h01;
            end
        end else begin
            // oscillator halts low between conversions
            next_osc_cnt = 8'h00;
            next_osc_level = 1'b0;
            // external edges only count while a conversion runs
            next_conv_fall = run && !use_int_osc && prev_ext && !clk_ext;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!por_n) begin
            osc_cnt <= 8'h00;
            osc_level <= 1'b0;
            prev_ext <= 1'b1;
            conv_fall <= 1'b0;
        end else begin
            osc_cnt <= next_osc_cnt;
            osc_level <= next_osc_level;
            prev_ext <= next_prev_ext;
            conv_fall <= next_conv_fall;
        end
    end
endmodule

/* File: sac_sar.sv */
// successive approximation register with its output latch
`timescale 1ns/1ps
`include "sac_cfg.svh"
module sac_sar (
    input wire logic clk_sys,
    input wire logic por_n,
    input wire logic load,
    input wire logic decide,
    input wire logic [2:0] bit_idx,
    input wire logic comp_in,
    output logic [7:0] trial,
    output logic [7:0] result
);
    logic [7:0] next_trial;
    logic [7:0] next_result;
    logic [7:0] dec_val;
    logic last;

    assign last = (bit_idx == `SAC_LAST_BIT);

    genvar gi;
    generate
        for (gi = 0; gi < `SAC_NUM_BITS; gi++) begin : g_bit
            // bit under test keeps comparator verdict; next lower bit is set for trial
            assign dec_val[gi] = (3'(7 - gi) == bit_idx) ? comp_in :
                                 ((3'(6 - gi) == bit_idx) && (gi != 7)) ? 1'b1 : trial[gi];
        end
    endgenerate

    always_comb begin
        next_trial = trial;
        next_result = result;
        if (load) begin
            next_trial = `SAC_CODE_START;
        end else if (decide) begin
            if (last) begin
                next_result = dec_val;
                next_trial = `SAC_CODE_RST;
            end else begin
                next_trial = dec_val;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!por_n) begin
            trial <= `SAC_CODE_RST;
            result <= `SAC_CODE_RST;
        end else begin
            trial <= next_trial;
            result <= next_result;
        end
    end
endmodule

/* File: sac_host_model.sv */
// host-side model: free-running external clock and ideal comparator
`timescale 1ns/1ps
module sac_host_model #(parameter int HALF = 20) (
    input wire logic clk_sys,
    input wire logic [7:0] vin,
    input wire logic [7:0] dac_trial,
    output logic clk_ext,
    output logic comp_in
);
    int cnt = 0;
    initial clk_ext = 1'b0;
    // clock keeps toggling between conversions
    always @(posedge clk_sys) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) clk_ext <= #1 ~clk_ext;
    end
    assign comp_in = (vin >= dac_trial);
endmodule

/* File: sac_conv_ctrl_chk.sv */
// assertions on the conversion control ports
`timescale 1ns/1ps
module sac_conv_ctrl_chk (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic por_n,
    input wire logic convert_strobe_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic use_int_osc,
    input wire logic busy_n,
    input wire logic int_n,
    input wire logic hold,
    input wire logic osc_run,
    input wire logic osc_level,
    input wire logic [7:0] parallel_data_bus,
    input wire logic data_oe
);
    logic [10:0] low_cnt;
    logic [10:0] next_low_cnt;
    always_comb begin
        next_low_cnt = busy_n ? 11'h000 : low_cnt + 11'h001;
    end
    always_ff @(posedge clk_sys) begin
        low_cnt <= por_n ? next_low_cnt : 11'h000;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!por_n);
    a_strobe_start: assert property (busy_n && $fell(convert_strobe_n) |=> !busy_n)
        else $error("strobe start not taken");
    a_sel_start: assert property (busy_n && $fell(cs_n | rd_n) |=> !busy_n)
        else $error("select start not taken");
    a_hold_track: assert property (hold != busy_n)
        else $error("hold not tied to busy");
    a_osc_halt: assert property (busy_n && $past(busy_n) |-> !osc_run && !osc_level)
        else $error("clock runs while idle");
    a_int_done: assert property ($rose(busy_n) |-> !int_n)
        else $error("no interrupt at completion");
    a_int_clear: assert property (busy_n && !int_n && ($rose(cs_n) || $rose(rd_n)) |=> int_n)
        else $error("interrupt not released");
    a_rst_int: assert property (!rstn && busy_n |=> int_n)
        else $error("reset left interrupt low");
    a_rst_keep: assert property (!rstn && !busy_n |=> !busy_n || !int_n)
        else $error("reset disturbed conversion");
    a_ext_len: assert property ($rose(busy_n) && !use_int_osc |-> low_cnt inside {[335:395]})
        else $error("external clock conversion length");
    a_osc_len: assert property ($rose(busy_n) && use_int_osc |-> low_cnt inside {[540:610]})
        else $error("internal clock conversion length");
    a_bus_quiet: assert property (!data_oe |-> parallel_data_bus == 8'h00)
        else $error("bus driven while unselected");
    c_strobe: cover property ($fell(busy_n) && convert_strobe_n == 1'b0 && cs_n);
    c_sel: cover property ($fell(busy_n) && !cs_n && convert_strobe_n);
    c_rst: cover property (!rstn && !busy_n && !int_n);
endmodule
bind sac_conv_ctrl sac_conv_ctrl_chk u_chk (.clk_sys, .rstn, .por_n, .convert_strobe_n, .cs_n, .rd_n,
    .use_int_osc, .busy_n, .int_n, .hold, .osc_run, .osc_level, .parallel_data_bus, .data_oe);

/* File: sac_conv_ctrl_tb_top.sv */
// self-checking bench for the conversion control
`timescale 1ns/1ps
module sac_conv_ctrl_tb_top;
    logic clk_sys, rstn, por_n, convert_strobe_n, cs_n, rd_n, clk_ext, use_int_osc, vss_neg, comp_in;
    logic busy_n, int_n, hold, osc_run, osc_level, data_oe, osc_seen;
    logic [7:0] dac_trial, parallel_data_bus, vin, rd_val;
    logic [7:0] vals [5] = '{8'h00, 8'hFF, 8'h5A, 8'hA5, 8'h81};
    int error_cnt, n_tests, cyc, n_low, lo_len, hi_len;
    sac_conv_ctrl u_dut (.clk_sys, .rstn, .por_n, .convert_strobe_n, .cs_n, .rd_n, .clk_ext, .use_int_osc,
        .vss_neg, .comp_in, .busy_n, .int_n, .hold, .osc_run, .osc_level, .dac_trial, .parallel_data_bus,
        .data_oe);
    sac_host_model u_host (.clk_sys, .vin, .dac_trial, .clk_ext, .comp_in);
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (osc_level === 1'b1) osc_seen <= 1'b1;
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (error_cnt == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // skip: cycles of the conversion already spent before the wait
    task automatic wait_done(input int skip);
        n_low = skip;
        while (busy_n !== 1'b1 && n_low < 2000) begin
            tick(1);
            n_low = n_low + 1;
        end
        chk("conv_len", {7'h00, n_low >= lo_len && n_low <= hi_len}, 8'h01);
    endtask
    // a read while idle also starts a conversion, so its end is awaited too
    task automatic read_word();
        tick(280);
        cs_n = 1'b0;
        rd_n = 1'b0;
        tick(2);
        rd_val = parallel_data_bus;
        chk("data_oe", {7'h00, data_oe}, 8'h01);
        cs_n = 1'b1;
        rd_n = 1'b1;
        tick(2);
        chk("int_release", {7'h00, int_n}, 8'h01);
        wait_done(2);
        tick(280);
    endtask
    task automatic t_strobe(input logic [7:0] v, input logic neg);
        vin = v;
        vss_neg = neg;
        convert_strobe_n = 1'b0;
        tick(2);
        chk("trial_msb", dac_trial, 8'h80);
        chk("hold_on", {7'h00, hold}, 8'h01);
        wait_done(0);
        chk("int_done", {7'h00, int_n}, 8'h00);
        chk("sar_clear", dac_trial, 8'h00);
        chk("hold_off", {7'h00, hold}, 8'h00);
        read_word();
        chk("result", rd_val, neg ? v ^ 8'h80 : v);
        convert_strobe_n = 1'b1;
        tick(1);
    endtask
    task automatic t_sel();
        vin = 8'h3C;
        vss_neg = 1'b0;
        cs_n = 1'b0;
        rd_n = 1'b0;
        tick(2);
        chk("sel_busy", {7'h00, busy_n}, 8'h00);
        wait_done(0);
        tick(2);
        chk("sel_word", parallel_data_bus, 8'h3C);
        cs_n = 1'b1;
        rd_n = 1'b1;
        tick(2);
        chk("sel_int", {7'h00, int_n}, 8'h01);
        tick(300);
    endtask
    task automatic t_busy();
        vin = 8'hC3;
        convert_strobe_n = 1'b0;
        tick(2);
        convert_strobe_n = 1'b1;
        wait_done(0);
        tick(300);
        vin = 8'h96;
        convert_strobe_n = 1'b0;
        tick(20);
        convert_strobe_n = 1'b1;
        tick(20);
        convert_strobe_n = 1'b0;
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        chk("rst_int", {7'h00, int_n}, 8'h01);
        chk("rst_busy", {7'h00, busy_n}, 8'h00);
        wait_done(40);
        read_word();
        chk("kept_word", rd_val, 8'h96);
        convert_strobe_n = 1'b1;
        tick(1);
    endtask
    task automatic t_osc();
        use_int_osc = 1'b1;
        lo_len = 540;
        hi_len = 610;
        osc_seen = 1'b0;
        t_strobe(8'h71, 1'b1);
        chk("osc_ran", {7'h00, osc_seen}, 8'h01);
        chk("osc_stop", {6'h00, osc_run, osc_level}, 8'h00);
        chk("int_pend", {7'h00, int_n}, 8'h00);
        rstn = 1'b0;
        tick(1);
        rstn = 1'b1;
        tick(1);
        chk("idle_rst", {7'h00, int_n}, 8'h01);
        chk("idle_rst_busy", {7'h00, busy_n}, 8'h01);
    endtask
    initial begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        por_n = 1'b0;
        convert_strobe_n = 1'b1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        use_int_osc = 1'b0;
        vss_neg = 1'b0;
        vin = 8'h00;
        error_cnt = 0;
        n_tests = 0;
        cyc = 0;
        osc_seen = 1'b0;
        lo_len = 335;
        hi_len = 395;
        tick(10);
        rstn = 1'b1;
        por_n = 1'b1;
        tick(1);
        chk("reset", {4'h0, busy_n, int_n, hold, data_oe}, 8'h0C);
        foreach (vals[i]) t_strobe(vals[i], i[0]);
        t_sel();
        t_busy();
        t_osc();
        print_verdict();
    end
endmodule
